// File: fgm_defs.svh
`ifndef FGM_DEFS_SVH
`define FGM_DEFS_SVH

// pin counts and grouping
`define FGM_NPINS      44
`define FGM_NGRP       4
`define FGM_PINS_SMALL 6'h0C
`define FGM_PINS_MID   6'h1C
`define FGM_PINS_LARGE 6'h2C

// package select codes
`define FGM_PKG_SMALL  2'h0
`define FGM_PKG_MID    2'h1
`define FGM_PKG_LARGE  2'h2

// per-group signal list sizes and select code width (code 0 means unrouted)
`define FGM_NIN        16
`define FGM_NOUT       21
`define FGM_NOUT_G1    18
`define FGM_SELW       5

// group 0 input indices
`define FGM_G0I_DEBUG      0
`define FGM_G0I_FIFO_D0    1
`define FGM_G0I_FIFO_D4    2
`define FGM_G0I_FIFO_OE_N  3
`define FGM_G0I_SLA_CLK    4
`define FGM_G0I_SLB_CLK    5
`define FGM_G0I_GPIO_BASE  6
// group 0 output indices
`define FGM_G0O_DEBUG      0
`define FGM_G0O_TXD        1
`define FGM_G0O_DTR_N      2
`define FGM_G0O_TX_ACTIVE  3
`define FGM_G0O_FIFO_D0    4
`define FGM_G0O_FIFO_D4    5
`define FGM_G0O_RXF_N      6
`define FGM_G0O_PWM0       7
`define FGM_G0O_PWM4       8
`define FGM_G0O_MST_CLK    9
`define FGM_G0O_MST_SEL1_N 10
`define FGM_G0O_GPIO_BASE  11
// group 1 input indices
`define FGM_G1I_RXD        0
`define FGM_G1I_DSR_N      1
`define FGM_G1I_FIFO_D1    2
`define FGM_G1I_FIFO_D5    3
`define FGM_G1I_SLA_MO     4
`define FGM_G1I_SLB_MO     5
`define FGM_G1I_GPIO_BASE  6
// group 1 output indices
`define FGM_G1O_FIFO_D1    0
`define FGM_G1O_FIFO_D5    1
`define FGM_G1O_TXE_N      2
`define FGM_G1O_PWM1       3
`define FGM_G1O_PWM5       4
`define FGM_G1O_SLA_MO     5
`define FGM_G1O_SLB_MO     6
`define FGM_G1O_FIFO_CLK   7
`define FGM_G1O_GPIO_BASE  8

// active-low input masks per group (bit set = idles high)
`define FGM_G0_IN_LOW  16'h0008
`define FGM_G1_IN_LOW  16'h0002
`define FGM_G2_IN_LOW  16'h0000
`define FGM_G3_IN_LOW  16'h0000

// default routing: debug line on pin 0, bidirectional
`define FGM_DEBUG_PIN  6'h00

`endif

// File: fgm_pkg.sv
package fgm_pkg;

	`include "fgm_defs.svh"

	typedef enum logic [1:0] {DIR_IN, DIR_OUT, DIR_BIDIR} fgm_dir_e;

	typedef logic [`FGM_SELW-1:0] fgm_sel_t;

	typedef struct packed {
		fgm_dir_e dir;
		fgm_sel_t isel;
		fgm_sel_t osel;
	} fgm_cfg_s;

endpackage

// File: fgm_pin_sync.sv
`timescale 1ns/1ps

module fgm_pin_sync #(
	parameter int W = 44
) (
	input  wire logic         clk,   // system clock
	input  wire logic         rst_n, // async reset, active low
	input  wire logic [W-1:0] din,   // raw pad levels
	output logic      [W-1:0] dout   // filtered levels
);

	typedef struct packed {
		logic [W-1:0] s1;
		logic [W-1:0] s2;
		logic [W-1:0] s3;
		logic [W-1:0] val;
	} fgm_sync_s;

	fgm_sync_s st_ff;
	fgm_sync_s nxt_st;

	////////////////////////////////////////////////////////////////////////////
	// three stages; a bit only moves once stages two and three agree,
	// so a single-cycle glitch past the first stage never reaches the peripherals
	always_comb begin
		nxt_st = st_ff;
		nxt_st.s1 = din;
		nxt_st.s2 = st_ff.s1;
		nxt_st.s3 = st_ff.s2;
		for (int i = 0; i < W; i++) begin
			if (st_ff.s2[i] == st_ff.s3[i]) begin
				nxt_st.val[i] = st_ff.s3[i];
			end
		end
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			st_ff <= '0;
		end else begin
			st_ff <= nxt_st;
		end
	end

	assign dout = st_ff.val;

endmodule

// File: fgm_pin_mux.sv
`timescale 1ns/1ps

module fgm_pin_mux
	import fgm_pkg::*;
(
	input  wire logic                  CLOCK,    // 100 MHz system clock
	input  wire logic                  RST_N,    // async reset, active low
	input  wire logic [1:0]            PKG_SEL,  // package: 0 small, 1 mid, 2 large
	input  wire logic                  MUX_EN,   // routing enable level
	input  wire logic                  CFG_WE,   // write one pin's routing
	input  wire logic [5:0]            CFG_PIN,  // pin index to write
	input  wire fgm_pkg::fgm_dir_e     CFG_DIR,  // pad direction to write
	input  wire fgm_pkg::fgm_sel_t     CFG_ISEL, // input select code, 0 = none
	input  wire fgm_pkg::fgm_sel_t     CFG_OSEL, // output select code, 0 = none
	input  wire logic [43:0]           PAD_IN,   // pad receive levels
	output logic      [43:0]           PAD_OUT,  // pad drive levels
	output logic      [43:0]           PAD_OE_N, // pad driver enable, low drives
	input  wire logic [20:0]           OUT_G0,   // group 0 peripheral outputs
	input  wire logic [20:0]           OUT_G1,   // group 1 peripheral outputs
	input  wire logic [20:0]           OUT_G2,   // group 2 peripheral outputs
	input  wire logic [20:0]           OUT_G3,   // group 3 peripheral outputs
	input  wire logic [20:0]           DRV_G0,   // group 0 bidir drive requests
	input  wire logic [20:0]           DRV_G1,   // group 1 bidir drive requests
	input  wire logic [20:0]           DRV_G2,   // group 2 bidir drive requests
	input  wire logic [20:0]           DRV_G3,   // group 3 bidir drive requests
	output logic      [15:0]           IN_G0,    // group 0 peripheral inputs
	output logic      [15:0]           IN_G1,    // group 1 peripheral inputs
	output logic      [15:0]           IN_G2,    // group 2 peripheral inputs
	output logic      [15:0]           IN_G3     // group 3 peripheral inputs
);

	import fgm_pkg::*;

	typedef struct packed {
		fgm_cfg_s [`FGM_NPINS-1:0]       cfg;
		logic     [`FGM_NPINS-1:0]       pad_out;
		logic     [`FGM_NPINS-1:0]       pad_oe_n;
		logic     [`FGM_NGRP-1:0][15:0]  in_val;
		logic                            en_prev;
	} fgm_state_s;

	fgm_state_s                        st_ff;
	fgm_state_s                        nxt_st;
	logic [`FGM_NPINS-1:0]             pad_sync;
	logic [`FGM_NGRP-1:0][20:0]        out_all;
	logic [`FGM_NGRP-1:0][20:0]        drv_all;

	////////////////////////////////////////////////////////////////////////////
	// helpers

	// pins the chosen package bonds out; unknown codes fall back to the smallest
	function automatic logic [5:0] pins_of(input logic [1:0] pkg);
		unique case (pkg)
			`FGM_PKG_MID:   pins_of = `FGM_PINS_MID;
			`FGM_PKG_LARGE: pins_of = `FGM_PINS_LARGE;
			default:        pins_of = `FGM_PINS_SMALL;
		endcase
	endfunction

	// a pin's group is its index modulo four
	function automatic logic [1:0] group_of(input int p);
		group_of = 2'(p % `FGM_NGRP);
	endfunction

	// resting level of each peripheral input of a group
	function automatic logic [15:0] idle_of(input int g);
		unique case (g)
			0:       idle_of = `FGM_G0_IN_LOW;
			1:       idle_of = `FGM_G1_IN_LOW;
			2:       idle_of = `FGM_G2_IN_LOW;
			default: idle_of = `FGM_G3_IN_LOW;
		endcase
	endfunction

	// a select code names a real list entry
	function automatic logic sel_ok(input fgm_sel_t s, input int n);
		sel_ok = (s != '0) && (int'(s) <= n);
	endfunction

	// output list length of a group; group 1 is shorter, so its top codes mean none
	function automatic int nout_of(input logic [1:0] g);
		nout_of = (g == 2'h1) ? `FGM_NOUT_G1 : `FGM_NOUT;
	endfunction

	// default routing, loaded on each rising enable: debug line bidirectional on pin 0, every other pin input
	function automatic fgm_cfg_s default_cfg(input int p);
		fgm_cfg_s c;
		c.dir  = DIR_IN;
		c.isel = '0;
		c.osel = '0;
		if (p == int'(`FGM_DEBUG_PIN)) begin
			c.dir  = DIR_BIDIR;
			c.isel = fgm_sel_t'(`FGM_G0I_DEBUG + 1);
			c.osel = fgm_sel_t'(`FGM_G0O_DEBUG + 1);
		end
		default_cfg = c;
	endfunction

	////////////////////////////////////////////////////////////////////////////
	// pad receivers come from outside the clock domain
	fgm_pin_sync #(
		.W (`FGM_NPINS)
	) u_sync (
		.clk   (CLOCK),
		.rst_n (RST_N),
		.din   (PAD_IN),
		.dout  (pad_sync)
	);

	// group lists gathered so a pin can index its own group
	assign out_all = {OUT_G3, OUT_G2, OUT_G1, OUT_G0};
	assign drv_all = {DRV_G3, DRV_G2, DRV_G1, DRV_G0};

	////////////////////////////////////////////////////////////////////////////
	// routing table, pad drivers and peripheral input selection
	always_comb begin
		logic [5:0]  npins;
		logic        live;
		logic        drive;
		logic        found;
		logic [1:0]  g;
		fgm_cfg_s    e;
		logic [4:0]  oi;
		logic [15:0] idl;
		npins = pins_of(PKG_SEL);
		live  = 1'b0;
		drive = 1'b0;
		found = 1'b0;
		g     = 2'h0;
		e     = '0;
		oi    = 5'h00;
		idl   = 16'h0000;
		nxt_st = st_ff;
		nxt_st.en_prev = MUX_EN;

		// each rising enable reloads the default table
		if (MUX_EN && !st_ff.en_prev) begin
			for (int p = 0; p < `FGM_NPINS; p++) begin
				nxt_st.cfg[p] = default_cfg(p);
			end
		end

		// a write in the same cycle lands on top of the reload, so it is kept;
		// pins the package lacks ignore writes
		if (CFG_WE && (CFG_PIN < npins)) begin
			nxt_st.cfg[CFG_PIN].dir  = CFG_DIR;
			nxt_st.cfg[CFG_PIN].isel = CFG_ISEL;
			nxt_st.cfg[CFG_PIN].osel = CFG_OSEL;
		end

		// pad drivers: only live pins of the package drive, and only when enabled
		for (int p = 0; p < `FGM_NPINS; p++) begin
			g    = group_of(p);
			e    = st_ff.cfg[p];
			live = MUX_EN && st_ff.en_prev && (6'(p) < npins);
			oi   = e.osel - 5'h01;
			drive = 1'b0;
			nxt_st.pad_out[p] = 1'b0;
			if (live && sel_ok(e.osel, nout_of(g))) begin
				nxt_st.pad_out[p] = out_all[g][oi];
				unique case (e.dir)
					DIR_OUT:   drive = 1'b1;
					DIR_BIDIR: drive = drv_all[g][oi];
					DIR_IN:    drive = 1'b0;
					default:   drive = 1'b0;
				endcase
			end
			nxt_st.pad_oe_n[p] = !drive;
		end

		// peripheral inputs: the lowest live pin of the right group wins;
		// an unfed input rests at its inactive level
		for (int gi = 0; gi < `FGM_NGRP; gi++) begin
			idl = idle_of(gi);
			for (int k = 0; k < `FGM_NIN; k++) begin
				nxt_st.in_val[gi][k] = idl[k];
				found = 1'b0;
				for (int p = gi; p < `FGM_NPINS; p += `FGM_NGRP) begin
					e    = st_ff.cfg[p];
					live = MUX_EN && st_ff.en_prev && (6'(p) < npins);
					if (!found && live && (e.dir != DIR_OUT)
						&& (e.isel == fgm_sel_t'(k + 1))) begin
						nxt_st.in_val[gi][k] = pad_sync[p];
						found = 1'b1;
					end
				end
			end
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// state register; reset leaves every pad an undriven input
	always_ff @(posedge CLOCK or negedge RST_N) begin
		if (!RST_N) begin
			st_ff.cfg      <= '0;
			st_ff.pad_out  <= '0;
			st_ff.pad_oe_n <= '1;
			st_ff.in_val   <= {`FGM_G3_IN_LOW, `FGM_G2_IN_LOW,
				`FGM_G1_IN_LOW, `FGM_G0_IN_LOW};
			st_ff.en_prev  <= 1'b0;
		end else begin
			st_ff <= nxt_st;
		end
	end

	// outputs straight from the state register
	assign PAD_OUT  = st_ff.pad_out;
	assign PAD_OE_N = st_ff.pad_oe_n;
	assign IN_G0    = st_ff.in_val[0];
	assign IN_G1    = st_ff.in_val[1];
	assign IN_G2    = st_ff.in_val[2];
	assign IN_G3    = st_ff.in_val[3];

endmodule

// File: fgm_ext.sv
`timescale 1ns/1ps

module fgm_ext (
	input  wire logic        clk,    // clock
	input  wire logic [43:0] drv,    // far side drives pin
	input  wire logic [43:0] val,    // far side level
	input  wire logic [43:0] d_out,  // mux drive level
	input  wire logic [43:0] d_oe_n, // mux enable, low drives
	output logic      [43:0] pad     // resolved pin level
);
	logic [43:0] junk = '0;

	////////////////////////////////
	// floating pins toggle every clock, so the input filter never passes them and holds the last steady level
	always @(posedge clk) begin
		junk <= ~junk;
	end

	// mux driver wins, then a driving far side passes its level unchanged
	always_comb begin
		for (int i = 0; i < 44; i++) begin
			pad[i] = !d_oe_n[i] ? d_out[i] : drv[i] ? val[i] : junk[i];
		end
	end
endmodule

// File: fgm_chk_asserts.sv
`timescale 1ns/1ps
`include "fgm_defs.svh"

module fgm_chk (
	input wire logic        CLOCK,    // clock
	input wire logic        RST_N,    // reset
	input wire logic [1:0]  PKG_SEL,  // package
	input wire logic        MUX_EN,   // enable
	input wire logic        CFG_WE,   // write
	input wire logic [43:0] PAD_OUT,  // drive level
	input wire logic [43:0] PAD_OE_N, // drive enable
	input wire logic [20:0] OUT_G0,   // g0 out
	input wire logic [20:0] DRV_G0,   // g0 drive
	input wire logic [15:0] IN_G0,    // g0 in
	input wire logic [15:0] IN_G1,    // g1 in
	input wire logic [15:0] IN_G2,    // g2 in
	input wire logic [15:0] IN_G3     // g3 in
);
	default clocking @(posedge CLOCK); endclocking
	default disable iff (!RST_N);

	////////////////////////////////
	// reload window with no write racing it
	sequence s_dflt;
		($rose(MUX_EN) && !CFG_WE) ##1 (MUX_EN && !CFG_WE)[*2];
	endsequence
	property p_rst;
		$rose(RST_N) |-> &PAD_OE_N && PAD_OUT == '0;
	endproperty
	property p_off;
		!MUX_EN |=> &PAD_OE_N;
	endproperty
	property p_idle;
		!MUX_EN |=> IN_G0 == `FGM_G0_IN_LOW && IN_G1 == `FGM_G1_IN_LOW
			&& IN_G2 == `FGM_G2_IN_LOW && IN_G3 == `FGM_G3_IN_LOW;
	endproperty
	property p_lat;
		$rose(MUX_EN) |=> &PAD_OE_N;
	endproperty
	property p_need;
		!(&PAD_OE_N) |-> $past(MUX_EN) && $past(MUX_EN, 2);
	endproperty
	property p_d0;
		s_dflt |=> PAD_OE_N[0] == !$past(DRV_G0[0]) && PAD_OUT[0] == $past(OUT_G0[0]);
	endproperty
	property p_doth;
		s_dflt |=> &PAD_OE_N[43:1];
	endproperty
	property p_pkg;
		PKG_SEL == `FGM_PKG_SMALL && $past(PKG_SEL) == `FGM_PKG_SMALL |-> &PAD_OE_N[43:12];
	endproperty

	a_rst: assert property (p_rst) else $error("pads active after reset");
	a_off: assert property (p_off) else $error("pad driven while disabled");
	a_idle: assert property (p_idle) else $error("input not idle");
	a_lat: assert property (p_lat) else $error("pad driven too early");
	a_need: assert property (p_need) else $error("drive without enable");
	a_d0: assert property (p_d0) else $error("pin 0 default wrong");
	a_doth: assert property (p_doth) else $error("default pin driven");
	a_pkg: assert property (p_pkg) else $error("pin beyond package");

	c_en: cover property ($rose(MUX_EN));
	c_wr: cover property (CFG_WE && MUX_EN);
	c_drv: cover property (!PAD_OE_N[0]);
endmodule

bind fgm_pin_mux fgm_chk i_chk (.CLOCK(CLOCK), .RST_N(RST_N), .PKG_SEL(PKG_SEL),
	.MUX_EN(MUX_EN), .CFG_WE(CFG_WE), .PAD_OUT(PAD_OUT), .PAD_OE_N(PAD_OE_N),
	.OUT_G0(OUT_G0), .DRV_G0(DRV_G0), .IN_G0(IN_G0), .IN_G1(IN_G1), .IN_G2(IN_G2),
	.IN_G3(IN_G3));

// File: four_group_pin_mux_test.sv
`timescale 1ns/1ps
`include "fgm_defs.svh"

module four_group_pin_mux_test;
	import fgm_pkg::*;
	logic        clk, rst_n, en, we;
	logic [1:0]  pkg;
	logic [5:0]  pin;
	fgm_dir_e    dir;
	fgm_sel_t    isel, osel;
	logic [43:0] pad_in, pad_out, oe_n, drv, val;
	logic [20:0] og[4], dg[4];
	logic [15:0] ig[4];
	logic [15:0] idle[4] = '{`FGM_G0_IN_LOW, `FGM_G1_IN_LOW, `FGM_G2_IN_LOW, `FGM_G3_IN_LOW};
	int          err_count, check_count;

	fgm_pin_mux i_dut (.CLOCK(clk), .RST_N(rst_n), .PKG_SEL(pkg), .MUX_EN(en), .CFG_WE(we),
		.CFG_PIN(pin), .CFG_DIR(dir), .CFG_ISEL(isel), .CFG_OSEL(osel), .PAD_IN(pad_in),
		.PAD_OUT(pad_out), .PAD_OE_N(oe_n), .OUT_G0(og[0]), .OUT_G1(og[1]), .OUT_G2(og[2]),
		.OUT_G3(og[3]), .DRV_G0(dg[0]), .DRV_G1(dg[1]), .DRV_G2(dg[2]), .DRV_G3(dg[3]),
		.IN_G0(ig[0]), .IN_G1(ig[1]), .IN_G2(ig[2]), .IN_G3(ig[3]));
	fgm_ext i_ext (.clk(clk), .drv(drv), .val(val), .d_out(pad_out), .d_oe_n(oe_n),
		.pad(pad_in));

	////////////////////////////////
	// 100 MHz clock
	initial begin
		clk = 0;
		forever #5 clk = ~clk;
	end

	task automatic chk(string n, logic [43:0] e, logic [43:0] s);
		check_count++;
		if (s !== e) begin
			err_count++;
			$display("mismatch %s expected %h seen %h", n, e, s);
		end
	endtask

	// one routing write, then room for table and pad registers to follow
	task automatic wr(int p, fgm_dir_e d, int i, int o);
		@(negedge clk);
		we = 1;
		pin = p[5:0];
		dir = d;
		isel = i[4:0];
		osel = o[4:0];
		@(negedge clk);
		we = 0;
		repeat (3) @(negedge clk);
	endtask

	task automatic idle_chk;
		for (int x = 0; x < 4; x++) chk("in_grp", idle[x], ig[x]);
	endtask

	task automatic t_rst;
		chk("oe_n", '1, oe_n);
		chk("pad_out", 0, pad_out);
		idle_chk();
	endtask

	task automatic t_dflt;
		en = 1;
		dg[0] = 21'h1;
		og[0] = 21'h1;
		repeat (4) @(negedge clk);
		chk("oe_n", 44'hfff_ffff_fffe, oe_n);
		chk("pad_out", 1, pad_out[0]);
		dg[0] = 21'h0;
		drv[0] = 1;
		val[0] = 1;
		repeat (6) @(negedge clk);
		chk("debug_in", 1, ig[0][0]);
		wr(0, DIR_IN, 0, 0);
	endtask

	// every output code of group g on a pin of that group; others carry the inverse
	task automatic t_out(int g, int n);
		logic [20:0] m;
		for (int k = 0; k < n; k++) begin
			m = 21'h1 << k;
			wr(8 + g, DIR_OUT, 0, k + 1);
			for (int x = 0; x < 4; x++) og[x] = (x == g) ? m : ~m;
			repeat (3) @(negedge clk);
			chk("pad_hi", 2'b10, {pad_out[8+g], oe_n[8+g]});
			for (int x = 0; x < 4; x++) og[x] = (x == g) ? ~m : m;
			repeat (3) @(negedge clk);
			chk("pad_lo", 0, pad_out[8+g]);
		end
		// first code past the group's list routes nothing
		wr(8 + g, DIR_OUT, 0, n + 1);
		chk("oe_n_ref", 1, oe_n[8+g]);
	endtask

	// every input code of group g fed from a pin of that group
	task automatic t_in(int g);
		logic [15:0] e;
		drv[4+g] = 1;
		for (int k = 0; k < 16; k++) begin
			wr(4 + g, DIR_IN, k + 1, 0);
			for (int v = 0; v < 2; v++) begin
				val[4+g] = v[0];
				repeat (6) @(negedge clk);
				e = idle[g];
				e[k] = v[0];
				for (int x = 0; x < 4; x++) chk("in_grp", x == g ? e : idle[x], ig[x]);
			end
		end
		wr(4 + g, DIR_IN, 0, 0);
	endtask

	// writes past the package pin count are dropped
	task automatic t_pkg;
		for (int x = 0; x < 4; x++) og[x] = '1;
		pkg = `FGM_PKG_SMALL;
		wr(12, DIR_OUT, 0, 1);
		chk("oe_n", 1, oe_n[12]);
		pkg = `FGM_PKG_MID;
		wr(27, DIR_OUT, 0, 1);
		wr(28, DIR_OUT, 0, 1);
		chk("oe_n", 2'b10, oe_n[28:27]);
		pkg = `FGM_PKG_LARGE;
		wr(43, DIR_OUT, 0, 1);
		chk("oe_n", 3'b110, {oe_n[12], oe_n[28], oe_n[43]});
	endtask

	task automatic t_off;
		en = 0;
		repeat (2) @(negedge clk);
		chk("oe_n", '1, oe_n);
		idle_chk();
	endtask

	task close_out;
		if (err_count == 0 && check_count > 0) begin
			$display("Run complete: PASS");
		end else begin
			$display("Run complete: FAIL");
		end
		$finish;
	endtask

	// watchdog: the sequence needs about 2100 cycles
	initial begin
		repeat (20000) @(posedge clk);
		err_count++;
		close_out();
	end

	initial begin
		rst_n = 0;
		pkg = `FGM_PKG_LARGE;
		en = 0;
		we = 0;
		pin = 0;
		dir = DIR_IN;
		isel = 0;
		osel = 0;
		og = '{default: '0};
		dg = '{default: '0};
		drv = '0;
		val = '0;
		repeat (4) @(negedge clk);
		rst_n = 1;
		@(negedge clk);
		t_rst();
		t_dflt();
		for (int g = 0; g < 4; g++) t_out(g, g == 1 ? 18 : 21);
		for (int g = 0; g < 4; g++) t_in(g);
		t_pkg();
		t_off();
		close_out();
	end
endmodule
